// *** core/quad_pot_regs.svh ***
`ifndef QUAD_POT_REGS_SVH
`define QUAD_POT_REGS_SVH

// slave address layout
`define ADDR_FIXED   5'h0b
`define HS_CODE      5'h01
`define GC_ADDR      8'h00

// broadcast command codes, bit 1 carries the ninth value bit
`define GC_WR_W0     8'b1000_00?0
`define GC_WR_W1     8'b1001_00?0
`define GC_WR_TC     8'b1100_00?0
`define GC_INC_W0    8'b1000_01?0
`define GC_INC_W1    8'b1001_01?0
`define GC_DEC_W0    8'b1000_10?0
`define GC_DEC_W1    8'b1001_10?0
`define D8_POS       1

// value register reset values and range
`define WIPER_RST    9'h080
`define TERMINAL_CONTROL_REG_RST     9'h1ff
`define WIPER_MAX    9'h100

// timing
`define CLK_NS       25
`define SPIKE_NS     10
`define SPIKE_CYC    ((`SPIKE_NS + `CLK_NS - 1) / `CLK_NS)
`define CAP_DELAY    2'h2

`endif

// *** core/quad_pot_pkg.sv ***
package quad_pot_pkg;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ADDR   = 3'b001,
        ST_GCCMD  = 3'b010,
        ST_GCDATA = 3'b011,
        ST_IGNORE = 3'b100,
        ST_SRWAIT = 3'b101,
        ST_SRHIGH = 3'b110
    } link_state_e;

    typedef enum logic [1:0] {
        OP_WRITE = 2'b00,
        OP_INC   = 2'b01,
        OP_DEC   = 2'b10
    } gc_op_e;

    typedef enum logic [1:0] {
        TG_W0   = 2'b00,
        TG_W1   = 2'b01,
        TG_TERMINAL_CONTROL_REG = 2'b10
    } gc_target_e;

    typedef struct packed {
        logic       valid;
        gc_op_e     op;
        gc_target_e tgt;
        logic       d8;
        logic [7:0] data;
    } gc_pend_s;

    typedef struct packed {
        logic scl;
        logic sda;
        logic linkBit;
        logic addrHigh;
        logic addrLow;
        logic broadcast_enable;
    } pins_s;

endpackage : quad_pot_pkg

// *** core/quad_pot_i2c_slave.sv ***
// What this block does
// - sda falling while scl high starts a transfer and restarts the decoder
// - in a repeated start, sda low at the scl rise is a collision
// - in a repeated start, scl falling before sda falls is a collision
// - sda rising while scl high ends the transfer
// - every stop returns the whole interface to idle
// - never hold scl low; only the data line is ever driven
// - malformed or cut-short transfers leave all stored values unchanged
// - address byte is fixed 01011, two pin bits, then read/write
// - low address pin is latched once after reset and then held
// - high-speed master code is not acknowledged but enters high speed
// - high speed ends at the next stop
// - in high speed, scl pulses shorter than 10 ns are ignored
// - broadcast address acknowledged only while broadcast enable is set
// - only own broadcast codes acknowledged, all others not acknowledged
// - one broadcast command per broadcast address; later bytes not acknowledged
// - write codes pick wiper 0, wiper 1 or terminal control; d is bit 8
// - increment codes add one to wiper 0 or wiper 1
// - decrement codes subtract one from wiper 0 or wiper 1
// - broadcast command byte always has a zero least significant bit
`timescale 1ns/1ps
`include "quad_pot_regs.svh"

module quad_pot_i2c_slave
    import quad_pot_pkg::*;
#(
    parameter int SPIKE_CYC = `SPIKE_CYC
) (
    // system
    input  wire logic       clk,
    input  wire logic       rstn,
    // serial link, scl is the link clock
    input  wire logic       scl,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    // address pins and broadcast enable
    input  wire logic       addrPinLow,
    input  wire logic       addrPinHigh,
    input  wire logic       broadcastEnable,
    // stored values
    output logic [8:0]      wiper0,
    output logic [8:0]      wiper1,
    output logic [8:0]      terminalControlReg,
    // status
    output logic            hsMode,
    output logic            busy,
    output logic            busCollision
);

    if (SPIKE_CYC < 1 || SPIKE_CYC > 15) begin : g_chk
        $error("SPIKE_CYC must be 1 to 15");
    end

    // link domain: sda as latched at the true scl rise
    logic linkBit_r;
    always_ff @(posedge scl or negedge rstn) begin
        if (!rstn) begin
            linkBit_r <= 1'b0;
        end else begin
            linkBit_r <= sdaIn;
        end
    end

    // two-flop synchronisers for every asynchronous input
    pins_s pinsRaw;
    pins_s syncQ1_r;
    pins_s sync_r;
    assign pinsRaw = '{scl: scl, sda: sdaIn, linkBit: linkBit_r, addrHigh: addrPinHigh,
                       addrLow: addrPinLow, broadcast_enable: broadcastEnable};
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncQ1_r <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
            sync_r   <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
        end else begin
            syncQ1_r <= pinsRaw;
            sync_r   <= syncQ1_r;
        end
    end

    link_state_e state_r;
    logic        hsMode_r;
    logic        sdaPrev_r;
    logic        sclFilt_r;
    logic        sclFiltQ_r;
    logic [3:0]  runCnt_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclFilt_r  <= 1'b1;
            sclFiltQ_r <= 1'b1;
            runCnt_r   <= 4'h0;
            sdaPrev_r  <= 1'b1;
        end else begin
            sclFiltQ_r <= sclFilt_r;
            sdaPrev_r  <= sync_r.sda;
            if (sync_r.scl == sclFilt_r) begin
                runCnt_r <= 4'h0;
            end else if (!hsMode_r || runCnt_r >= 4'(SPIKE_CYC)) begin
                sclFilt_r <= sync_r.scl;
                runCnt_r  <= 4'h0;
            end else begin
                runCnt_r <= runCnt_r + 4'h1;
            end
        end
    end

    logic sclRise;
    logic sclFall;
    logic startDet;
    logic stopDet;
    assign sclRise  = sclFilt_r & ~sclFiltQ_r;
    assign sclFall  = ~sclFilt_r & sclFiltQ_r;
    assign startDet = sclFilt_r & sync_r.scl & sdaPrev_r & ~sync_r.sda;
    assign stopDet  = sclFilt_r & sync_r.scl & ~sdaPrev_r & sync_r.sda;

    // latch the low address pin once after reset release
    logic [1:0] capCnt_r;
    logic       capDone_r;
    logic       addrLowLatched_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            capCnt_r         <= 2'h0;
            capDone_r        <= 1'b0;
            addrLowLatched_r <= 1'b0;
        end else if (!capDone_r) begin
            capCnt_r <= capCnt_r + 2'h1;
            if (capCnt_r == `CAP_DELAY) begin
                addrLowLatched_r <= sync_r.addrLow;
                capDone_r        <= 1'b1;
            end
        end
    end

    logic [3:0]  bitCnt_r;
    logic [7:0]  rxByte_r;
    logic        sdaOe_r;
    logic        sdaOut_r;
    logic        collision_r;
    logic        commit_r;
    link_state_e after_r;
    gc_pend_s    pend_r;
    logic        byteDone;
    logic        ackEnd;
    logic        active;
    assign byteDone = sclFall && bitCnt_r == 4'h8;
    assign ackEnd   = sclFall && bitCnt_r == 4'h9;
    assign active   = state_r inside {ST_ADDR, ST_GCCMD, ST_GCDATA, ST_IGNORE};

    // byte decode
    logic        ack_nxt;
    logic        hsHit;
    link_state_e after_nxt;
    gc_pend_s    pend_nxt;
    logic [6:0]  myAddr;
    assign myAddr = {`ADDR_FIXED, sync_r.addrHigh, addrLowLatched_r};

    always_comb begin
        ack_nxt   = 1'b0;
        hsHit     = 1'b0;
        after_nxt = ST_IGNORE;
        pend_nxt  = pend_r;
        unique case (state_r)
            ST_ADDR: begin
                if (rxByte_r[7:3] == `HS_CODE) begin
                    hsHit     = 1'b1;
                    after_nxt = ST_SRWAIT;
                end else if (rxByte_r == `GC_ADDR) begin
                    ack_nxt = sync_r.broadcast_enable;
                    if (sync_r.broadcast_enable) begin
                        after_nxt = ST_GCCMD;
                    end
                end else if (rxByte_r[7:1] == myAddr) begin
                    ack_nxt = 1'b1;
                end
            end
            ST_GCCMD: begin
                ack_nxt       = 1'b1;
                pend_nxt.d8   = rxByte_r[`D8_POS];
                pend_nxt.data = 8'h00;
                pend_nxt.valid = 1'b1;
                casez (rxByte_r)
                    // write codes wait for third byte
                    `GC_WR_W0: begin
                        pend_nxt  = '{valid: 1'b0, op: OP_WRITE, tgt: TG_W0,
                                      d8: rxByte_r[`D8_POS], data: 8'h00};
                        after_nxt = ST_GCDATA;
                    end
                    `GC_WR_W1: begin
                        pend_nxt  = '{valid: 1'b0, op: OP_WRITE, tgt: TG_W1,
                                      d8: rxByte_r[`D8_POS], data: 8'h00};
                        after_nxt = ST_GCDATA;
                    end
                    `GC_WR_TC: begin
                        pend_nxt  = '{valid: 1'b0, op: OP_WRITE, tgt: TG_TERMINAL_CONTROL_REG,
                                      d8: rxByte_r[`D8_POS], data: 8'h00};
                        after_nxt = ST_GCDATA;
                    end
                    `GC_INC_W0: begin
                        pend_nxt.op  = OP_INC;
                        pend_nxt.tgt = TG_W0;
                    end
                    `GC_INC_W1: begin
                        pend_nxt.op  = OP_INC;
                        pend_nxt.tgt = TG_W1;
                    end
                    `GC_DEC_W0: begin
                        pend_nxt.op  = OP_DEC;
                        pend_nxt.tgt = TG_W0;
                    end
                    `GC_DEC_W1: begin
                        pend_nxt.op  = OP_DEC;
                        pend_nxt.tgt = TG_W1;
                    end
                    default: begin
                        ack_nxt        = 1'b0;
                        pend_nxt.valid = 1'b0;
                    end
                endcase
            end
            ST_GCDATA: begin
                // third byte gives the low eight bits
                ack_nxt        = 1'b1;
                pend_nxt.data  = rxByte_r;
                pend_nxt.valid = 1'b1;
            end
            ST_IDLE, ST_IGNORE, ST_SRWAIT, ST_SRHIGH: begin
                pend_nxt = pend_r;
            end
            default: begin
                pend_nxt = pend_r;
            end
        endcase
    end

    // protocol engine
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r     <= ST_IDLE;
            after_r     <= ST_IGNORE;
            bitCnt_r    <= 4'h0;
            rxByte_r    <= 8'h00;
            sdaOe_r     <= 1'b0;
            hsMode_r    <= 1'b0;
            collision_r <= 1'b0;
            commit_r    <= 1'b0;
            pend_r      <= '0;
        end else begin
            collision_r <= 1'b0;
            commit_r    <= 1'b0;
            if (stopDet) begin
                // stop clears state, bit count, ack drive and pending command, leaves high speed
                state_r      <= ST_IDLE;
                hsMode_r     <= 1'b0;
                sdaOe_r      <= 1'b0;
                bitCnt_r     <= 4'h0;
                pend_r.valid <= 1'b0;
            end else if (startDet) begin
                state_r      <= ST_ADDR;
                sdaOe_r      <= 1'b0;
                bitCnt_r     <= 4'h0;
                pend_r.valid <= 1'b0;
            end else if ((state_r == ST_SRWAIT && sclRise && !sync_r.linkBit)
                         || (state_r == ST_SRHIGH && sclFall)) begin
                state_r      <= ST_IDLE;
                hsMode_r     <= 1'b0;
                sdaOe_r      <= 1'b0;
                bitCnt_r     <= 4'h0;
                pend_r.valid <= 1'b0;
                collision_r  <= 1'b1;
            end else if (state_r == ST_SRWAIT) begin
                // master must restart after the high-speed code
                if (sclRise) begin
                    state_r <= ST_SRHIGH;
                end
            end else if (active) begin
                if (sclRise) begin
                    bitCnt_r <= bitCnt_r + 4'h1;
                    if (bitCnt_r < 4'h8) begin
                        rxByte_r <= {rxByte_r[6:0], sync_r.linkBit};
                    end
                end else if (byteDone) begin
                    // only sda is driven, ignored bytes not acknowledged
                    sdaOe_r <= ack_nxt && state_r != ST_IGNORE;
                    after_r <= after_nxt;
                    if (state_r != ST_IGNORE) begin
                        pend_r <= pend_nxt;
                    end
                    if (hsHit) begin
                        hsMode_r <= 1'b1;
                    end
                end else if (ackEnd) begin
                    sdaOe_r      <= 1'b0;
                    bitCnt_r     <= 4'h0;
                    state_r      <= after_r;
                    commit_r     <= pend_r.valid;
                    pend_r.valid <= 1'b0;
                end
            end
        end
    end

    function automatic logic [8:0] stepVal(input logic [8:0] cur, input gc_op_e op);
        logic [8:0] res;
        res = cur;
        if (op == OP_INC && cur < `WIPER_MAX) begin
            res = cur + 9'h001;
        end else if (op == OP_DEC && cur != 9'h000) begin
            res = cur - 9'h001;
        end
        return res;
    endfunction : stepVal

    // stored values change only on a completed command
    logic [8:0] wiper0_r;
    logic [8:0] wiper1_r;
    logic [8:0] terminal_control_reg_r;
    logic [8:0] wrVal;
    assign wrVal = {pend_r.d8, pend_r.data};
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wiper0_r <= `WIPER_RST;
            wiper1_r <= `WIPER_RST;
            terminal_control_reg_r   <= `TERMINAL_CONTROL_REG_RST;
        end else if (commit_r) begin
            unique case (pend_r.tgt)
                TG_W0:   wiper0_r <= (pend_r.op == OP_WRITE) ? wrVal : stepVal(wiper0_r, pend_r.op);
                TG_W1:   wiper1_r <= (pend_r.op == OP_WRITE) ? wrVal : stepVal(wiper1_r, pend_r.op);
                TG_TERMINAL_CONTROL_REG: terminal_control_reg_r   <= wrVal;
                default: terminal_control_reg_r   <= terminal_control_reg_r;
            endcase
        end
    end

    logic busy_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_r   <= 1'b0;
            sdaOut_r <= 1'b0;
        end else begin
            busy_r   <= state_r != ST_IDLE;
            sdaOut_r <= 1'b0;
        end
    end

    assign sdaOut             = sdaOut_r;
    assign sdaOe              = sdaOe_r;
    assign wiper0             = wiper0_r;
    assign wiper1             = wiper1_r;
    assign terminalControlReg = terminal_control_reg_r;
    assign hsMode             = hsMode_r;
    assign busy               = busy_r;
    assign busCollision       = collision_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_startAddr;
        startDet && !stopDet |=> state_r == ST_ADDR && bitCnt_r == 4'h0 && !sdaOe_r;
    endproperty
    a_startAddr: assert property (p_startAddr) else $error("start not handled");
    property p_collLow;
        state_r == ST_SRWAIT && sclRise && !sync_r.linkBit && !startDet && !stopDet
            |=> collision_r && state_r == ST_IDLE;
    endproperty
    a_collLow: assert property (p_collLow) else $error("low sda collision missed");
    property p_collFall;
        state_r == ST_SRHIGH && sclFall && !startDet && !stopDet |=> collision_r ##1 !collision_r;
    endproperty
    a_collFall: assert property (p_collFall) else $error("early scl fall missed");
    property p_stopIdle;
        stopDet |=> state_r == ST_IDLE && !sdaOe_r && !hsMode_r ##1 !busy_r;
    endproperty
    a_stopIdle: assert property (p_stopIdle) else $error("stop did not idle");
    property p_abortKeeps;
        (startDet || stopDet) |=> ##1 $stable(wiper0_r) && $stable(wiper1_r) && $stable(terminal_control_reg_r);
    endproperty
    a_abortKeeps: assert property (p_abortKeeps) else $error("abort changed a value");
    property p_hsEnter;
        state_r == ST_ADDR && byteDone && rxByte_r[7:3] == `HS_CODE && !startDet && !stopDet
            |=> hsMode_r && !sdaOe_r;
    endproperty
    a_hsEnter: assert property (p_hsEnter) else $error("high speed entry wrong");
    property p_gcGate;
        state_r == ST_ADDR && byteDone && rxByte_r == `GC_ADDR && !sync_r.broadcast_enable
            && !startDet && !stopDet |=> !sdaOe_r;
    endproperty
    a_gcGate: assert property (p_gcGate) else $error("broadcast acked while off");
    property p_ignoreQuiet;
        state_r == ST_IGNORE |-> !sdaOe_r;
    endproperty
    a_ignoreQuiet: assert property (p_ignoreQuiet) else $error("ignored byte acked");
    property p_addrAck;
        state_r == ST_ADDR && byteDone && rxByte_r[7:1] == myAddr && !startDet && !stopDet
            |=> sdaOe_r;
    endproperty
    a_addrAck: assert property (p_addrAck) else $error("own address not acked");
    property p_collRelease;
        collision_r |-> !sdaOe_r && state_r == ST_IDLE;
    endproperty
    a_collRelease: assert property (p_collRelease) else $error("collision kept sda");
    property p_spike;
        hsMode_r && sync_r.scl != sclFilt_r && runCnt_r == 4'h0 |=> $stable(sclFilt_r);
    endproperty
    a_spike: assert property (p_spike) else $error("scl spike passed");
    property p_latchHold;
        capDone_r |=> $stable(addrLowLatched_r);
    endproperty
    a_latchHold: assert property (p_latchHold) else $error("address latch moved");

    c_hs: cover property (hsMode_r ##[1:1000] state_r == ST_ADDR);
    c_gcWrite: cover property (commit_r && pend_r.op == OP_WRITE);
    c_collision: cover property (collision_r);
    c_inc: cover property (commit_r && pend_r.op == OP_INC);

endmodule : quad_pot_i2c_slave

// *** bench/i2c_master_model.sv ***
`timescale 1ns/1ps
module i2c_master_model (
    // bus pins
    output logic      sclOut,
    output logic      sdaOut,
    input  wire logic sdaWire
);
    localparam realtime Q = 31.25;

    // bus idles released, clock stands high
    initial begin
        sclOut = 1'b1;
        sdaOut = 1'b1;
    end

    task automatic start();
        // offset keeps link edges off the system clock edges
        #7;
        sdaOut = 1'b1;
        #Q sclOut = 1'b1;
        #(2*Q) sdaOut = 1'b0;
        #(2*Q) sclOut = 1'b0;
        #Q;
    endtask : start

    task automatic sendBit(input logic b, input logic spk);
        sdaOut = b;
        #Q sclOut = 1'b1;
        if (spk) begin
            // full high phase first, so the filter has seen the rise before the spike
            #(2*Q) sclOut = 1'b0;
            #10 sclOut = 1'b1;
            #Q;
        end else begin
            #(2*Q);
        end
        sclOut = 1'b0;
        #Q;
    endtask : sendBit

    // ack clock low phases stretched to give the slave time to answer
    task automatic sendByte(input logic [7:0] b, input logic spk, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sendBit(b[i], spk);
        end
        sdaOut = 1'b1;
        #(5*Q) sclOut = 1'b1;
        #Q ack = ~sdaWire;
        #Q sclOut = 1'b0;
        #(6*Q);
    endtask : sendByte

    task automatic stop();
        sdaOut = 1'b0;
        #Q sclOut = 1'b1;
        #(2*Q) sdaOut = 1'b1;
        #(2*Q);
    endtask : stop

    task automatic collide(input logic lowAtRise);
        sdaOut = ~lowAtRise;
        #Q sclOut = 1'b1;
        #(2*Q);
        if (!lowAtRise) begin
            sclOut = 1'b0;
            #Q stop();
        end else begin
            // hold sda low past the seen rise so the release is not taken first as a stop
            #(2*Q) sdaOut = 1'b1;
            #(2*Q);
        end
    endtask : collide
endmodule : i2c_master_model

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED at %0t got %h expected %h", $time, g, e); end end
module tb_top;
    logic       clk;
    logic       rstn;
    logic       scl;
    logic       sdaM;
    logic       sdaDut;
    logic       sdaOe;
    logic       sdaWire;
    logic       addrPinLow;
    logic       addrPinHigh;
    logic       broadcastEnable;
    logic [8:0] wiper0;
    logic [8:0] wiper1;
    logic [8:0] tconReg;
    logic       hsMode;
    logic       busy;
    logic       busCollision;
    logic [8:0] expW0;
    logic [8:0] expW1;
    logic [8:0] expTc;
    logic       ack;
    int         n_mismatch = 0;
    int         compares = 0;
    int         nColl = 0;
    logic [7:0] codes [8] = '{8'h84, 8'h86, 8'h8a, 8'h88, 8'h98, 8'h9a, 8'h94, 8'h96};
    logic [7:0] badCodes [5] = '{8'h06, 8'h04, 8'h81, 8'ha0, 8'h8e};

    // pull-up wire, low when either side pulls
    assign sdaWire = sdaM & (sdaOe ? sdaDut : 1'b1);

    quad_pot_i2c_slave #(.SPIKE_CYC(1)) quad_pot_i2c_slave_i (
        .clk(clk), .rstn(rstn), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaDut),
        .sdaOe(sdaOe), .addrPinLow(addrPinLow), .addrPinHigh(addrPinHigh),
        .broadcastEnable(broadcastEnable), .wiper0(wiper0), .wiper1(wiper1),
        .terminalControlReg(tconReg), .hsMode(hsMode), .busy(busy),
        .busCollision(busCollision)
    );

    i2c_master_model i2c_master_model_i (.sclOut(scl), .sdaOut(sdaM), .sdaWire(sdaWire));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (busCollision === 1'b1) begin
            nColl <= nColl + 1;
        end
    end

    task automatic end_sim();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    function automatic logic [8:0] adj(input logic [8:0] v, input logic up);
        if (up) return (v == 9'h100) ? v : v + 9'h001;
        return (v == 9'h000) ? v : v - 9'h001;
    endfunction : adj

    // each transfer opens with a start
    task automatic xfer(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                        input int n, input logic [2:0] expAck);
        logic [7:0] bytes [3];
        bytes = '{b0, b1, b2};
        i2c_master_model_i.start();
        for (int i = 0; i < n; i++) begin
            i2c_master_model_i.sendByte(bytes[i], 1'b0, ack);
            `CHK(ack, expAck[2-i])
        end
        i2c_master_model_i.stop();
        repeat (8) @(posedge clk);
        `CHK(busy, 1'b0)
    endtask : xfer

    task automatic chkRegs();
        `CHK(wiper0, expW0)
        `CHK(wiper1, expW1)
        `CHK(tconReg, expTc)
    endtask : chkRegs

    initial begin
        #2000000;
        n_mismatch++;
        end_sim();
    end

    initial begin
        rstn = 1'b0;
        addrPinLow = 1'b0;
        addrPinHigh = 1'b1;
        broadcastEnable = 1'b0;
        expW0 = 9'h080;
        expW1 = 9'h080;
        expTc = 9'h1ff;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (8) @(posedge clk);
        chkRegs();
        `CHK(hsMode, 1'b0)
        addrPinLow <= 1'b1;
        xfer(8'h5c, 8'h00, 8'h00, 1, 3'b100);
        xfer(8'h5e, 8'h00, 8'h00, 1, 3'b000);
        xfer(8'h7c, 8'h00, 8'h00, 1, 3'b000);
        xfer(8'h00, 8'h80, 8'hff, 3, 3'b000);
        chkRegs();
        @(posedge clk);
        broadcastEnable <= 1'b1;
        repeat (4) @(posedge clk);
        xfer(8'h00, 8'h80, 8'hff, 3, 3'b111);
        xfer(8'h00, 8'h92, 8'h00, 3, 3'b111);
        xfer(8'h00, 8'hc2, 8'h34, 3, 3'b111);
        expW0 = 9'h0ff;
        expW1 = 9'h100;
        expTc = 9'h134;
        chkRegs();
        for (int i = 0; i < 8; i++) begin
            xfer(8'h00, codes[i], 8'h00, 2, 3'b110);
            if (codes[i][4]) expW1 = adj(expW1, codes[i][2]);
            else expW0 = adj(expW0, codes[i][2]);
            chkRegs();
        end
        xfer(8'h00, 8'h84, 8'h84, 3, 3'b110);
        expW0 = adj(expW0, 1'b1);
        chkRegs();
        foreach (badCodes[i]) begin
            xfer(8'h00, badCodes[i], 8'h11, 3, 3'b100);
        end
        xfer(8'h00, 8'h82, 8'h00, 2, 3'b110);
        chkRegs();
        i2c_master_model_i.start();
        i2c_master_model_i.sendByte(8'h0d, 1'b0, ack);
        `CHK(ack, 1'b0)
        `CHK(hsMode, 1'b1)
        // restart then own address at high speed
        i2c_master_model_i.start();
        i2c_master_model_i.sendByte(8'h5c, 1'b1, ack);
        `CHK(ack, 1'b1)
        i2c_master_model_i.stop();
        repeat (8) @(posedge clk);
        `CHK(hsMode, 1'b0)
        `CHK(busy, 1'b0)
        for (int k = 0; k < 2; k++) begin
            i2c_master_model_i.start();
            i2c_master_model_i.sendByte(8'h08, 1'b0, ack);
            i2c_master_model_i.collide(k == 0);
            repeat (8) @(posedge clk);
            `CHK(nColl, k + 1)
            `CHK(hsMode, 1'b0)
            `CHK(sdaOe, 1'b0)
        end
        chkRegs();
        end_sim();
    end
endmodule : tb_top
